// ### design/i2cs_pkg.sv
// i2c slave package: register indices, field positions, reset values, modes
// assumes a plain address/strobe register port of width REG_AW
package i2cs_pkg;
    // ------------------------------------------------------------
    // register indices on the plain software port
    // ------------------------------------------------------------
    localparam int REG_AW = 4;
    localparam logic [3:0] OFS_STATUS = 4'h0; // port_status_reg
    localparam logic [3:0] OFS_BUF = 4'h1; // shift_buffer_reg
    localparam logic [3:0] OFS_ADDR = 4'h2; // slave_address_reg
    localparam logic [3:0] OFS_MASK = 4'h3; // address_mask_reg
    localparam logic [3:0] OFS_CON1 = 4'h4; // port_control_one
    localparam logic [3:0] OFS_CON2 = 4'h5; // port_control_two
    localparam logic [3:0] OFS_CON3 = 4'h6; // port_control_three
    localparam logic [3:0] OFS_CLKPS = 4'h7; // clock_input_pin_select
    localparam logic [3:0] OFS_DATPS = 4'h8; // data_input_pin_select
    localparam logic [3:0] OFS_IRQ = 4'h9; // serial_port_irq_flag in bit 0
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ST_BF = 0; // buffer_full_flag
    localparam int ST_UA = 1; // update_address_bit
    localparam int ST_RW = 2;
    localparam int ST_S = 3;
    localparam int ST_P = 4;
    localparam int ST_DA = 5;
    localparam int C1_CKP = 4; // clock_release_bit
    localparam int C1_EN = 5;
    localparam int C1_OV = 6;
    localparam int C2_SEN = 0; // stretch_enable_bit
    localparam int C2_ACKDT = 5;
    localparam int C3_DATA_HOLD_ENABLE = 0; // data_hold_enable
    localparam int C3_ADDRESS_HOLD_ENABLE = 1; // address_hold_enable
    localparam int C3_SCIE = 5; // start interrupt enable
    // ------------------------------------------------------------
    // reset values and mode codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CON1 = 8'h10; // clock released
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [3:0] MODE_7BIT = 4'h6;
    localparam logic [3:0] MODE_10BIT = 4'h7;
    localparam logic [4:0] TENBIT_HDR = 5'h1e; // 11110 prefix
    localparam logic [3:0] BIT_LAST = 4'h8; // eighth falling edge
    localparam logic [3:0] BIT_ACK = 4'h9; // ninth falling edge
    // engine states, gray along idle-addr-data-tx-wait
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_DATA = 3'b011,
        ST_TX = 3'b010,
        ST_WAIT = 3'b110
    } i2cs_state_e;
endpackage

// ### design/i2cs_top.sv
// i2c slave receive engine with 10-bit addressing, hold options and stretching
// assumes open-drain wiring outside; SCL/SDA arrive asynchronously
// Functional notes
// - start sets status, irq if enabled
// - matching high write address: UA, ack, irq
// - reading buffer clears buffer-full flag
// - low mismatch: irq, UA, no BF, CLOCK_RELEASE_BIT kept
// - UA in 10-bit mode holds SCL
// - address write releases held SCL
// - data byte acked on ninth pulse, irq
// - stretch enable clears CLOCK_RELEASE_BIT after ack
// - read request always clears CLOCK_RELEASE_BIT
// - stretch ignores buffer-full state
// - pull SCL only after seen low
// - hold until CLOCK_RELEASE_BIT set, then wired-and
// - address hold clears CLOCK_RELEASE_BIT at eighth edge
// - data hold clears CLOCK_RELEASE_BIT at eighth edge
// - 10-bit hold behaves as 7-bit
`timescale 1ns/1ns
module i2cs_top
    import i2cs_pkg::*;
(
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    // software register port
    input wire logic [REG_AW-1:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    // i2c pins, open drain
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE_O,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // event flag level
    output logic IRQ_FLAG_O
);
    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [2:0] scl_q; // [0] is first sync stage only
    logic [2:0] sda_q;
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], SCL_I};
            sda_q <= {sda_q[1:0], SDA_I};
        end
    end
    wire scl_s = scl_q[1];
    wire sda_s = sda_q[1];
    wire scl_rise = scl_q[1] & ~scl_q[2];
    wire scl_fall = ~scl_q[1] & scl_q[2];
    wire bus_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    wire bus_stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] addr_q, mask_q, con1_q, con2_q, con3_q, clkps_q, datps_q, buf_q;
    logic bf_q, ua_q, rw_q, s_q, p_q, da_q, irq_q, ov_q, ckp_q;
    logic [7:0] rdata_q;
    // address comparison, used for high, low and 7-bit bytes
    function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] a,
                                      input logic [7:0] m, input logic full);
        logic [7:0] care;
        care = full ? m : (m & 8'hfe);
        return ((b ^ a) & care) == 8'h00;
    endfunction
    wire wr_addr = REG_WR_I && (REG_ADDR_I == OFS_ADDR);
    wire wr_buf = REG_WR_I && (REG_ADDR_I == OFS_BUF);
    wire wr_con1 = REG_WR_I && (REG_ADDR_I == OFS_CON1);
    wire wr_irq = REG_WR_I && (REG_ADDR_I == OFS_IRQ);
    wire rd_buf = REG_RD_I && (REG_ADDR_I == OFS_BUF);
    wire enabled = con1_q[C1_EN];
    wire tenbit = con1_q[3:0] == MODE_10BIT;
    wire [7:0] status_w = {2'h0, da_q, p_q, s_q, rw_q, ua_q, bf_q};
    // ------------------------------------------------------------
    // byte engine state
    // ------------------------------------------------------------
    i2cs_state_e st_q;
    logic [3:0] cnt_q; // falling edges within the byte
    logic [7:0] sh_q; // receive shifter
    logic [7:0] tx_q; // transmit shifter
    logic low_ph_q; // next address byte is the 10-bit low byte
    logic full_hit_q; // full 10-bit address matched earlier
    logic ack_q; // acknowledge decided for this byte
    logic hold_ack_q; // software decides acknowledge via ACKDT
    logic rd_hit_q; // acked address byte asked for a read, kept past the ack bit shift
    wire fall8 = scl_fall && (cnt_q == BIT_LAST - 4'h1);
    wire fall9 = scl_fall && (cnt_q == BIT_ACK - 4'h1);
    wire [7:0] byte_w = sh_q;
    wire hi_hdr = byte_w[7:3] == TENBIT_HDR;
    // decisions taken on the eighth falling edge
    wire hit7 = !tenbit && addr_hit(byte_w, addr_q, mask_q, 1'b0);
    wire hit_hi_w = tenbit && !low_ph_q && hi_hdr && !byte_w[0] && addr_hit(byte_w, addr_q, mask_q, 1'b0);
    wire hit_hi_r = tenbit && !low_ph_q && hi_hdr && byte_w[0] && full_hit_q;
    wire hit_lo = tenbit && low_ph_q && addr_hit(byte_w, addr_q, mask_q, 1'b1);
    wire addr_match = hit7 || hit_hi_w || hit_hi_r || hit_lo;
    wire ack_drive = hold_ack_q ? !con2_q[C2_ACKDT] : 1'b1;
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            low_ph_q <= 1'b0;
            full_hit_q <= 1'b0;
            ack_q <= 1'b0;
            hold_ack_q <= 1'b0;
            rd_hit_q <= 1'b0;
        end else if (!enabled || bus_stop) begin
            // stop or disable returns to idle; only a stop drops the full 10-bit match
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            low_ph_q <= 1'b0;
            ack_q <= 1'b0;
            full_hit_q <= bus_stop ? 1'b0 : full_hit_q;
        end else if (bus_start) begin
            // repeated start keeps a full 10-bit match for reads
            st_q <= ST_ADDR;
            // the start's own scl fall wraps this to zero, so it is not counted as a bit
            cnt_q <= 4'hf;
            low_ph_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            if (scl_rise) begin
                sh_q <= {sh_q[6:0], sda_s};
            end
            if (scl_fall) begin
                cnt_q <= fall9 ? 4'h0 : cnt_q + 4'h1;
            end
            if (fall8 && st_q == ST_ADDR) begin
                ack_q <= addr_match;
                hold_ack_q <= con3_q[C3_ADDRESS_HOLD_ENABLE];
                rd_hit_q <= hit_hi_r || (hit7 && byte_w[0]);
            end else if (fall8 && st_q == ST_DATA) begin
                ack_q <= 1'b1;
                hold_ack_q <= con3_q[C3_DATA_HOLD_ENABLE];
            end else if (fall9) begin
                ack_q <= 1'b0;
                hold_ack_q <= 1'b0;
            end
            // next state after the acknowledge slot
            if (fall9 && st_q == ST_ADDR) begin
                if (!ack_q) begin
                    st_q <= ST_WAIT;
                end else if (rd_hit_q) begin
                    st_q <= ST_TX;
                end else if (tenbit && !low_ph_q) begin
                    low_ph_q <= 1'b1;
                end else begin
                    st_q <= ST_DATA;
                    full_hit_q <= tenbit;
                end
            end
            if (st_q == ST_TX && scl_rise && cnt_q == BIT_LAST && sda_s) begin
                // master declined more data
                st_q <= ST_WAIT;
            end
        end
    end
    // ------------------------------------------------------------
    // status flags, buffer and clock release
    // ------------------------------------------------------------
    wire rx_byte = fall8 && (st_q == ST_DATA || (st_q == ST_ADDR && addr_match));
    wire ov_set = rx_byte && bf_q && !rd_buf;
    wire hold_clr = fall8 && ((st_q == ST_ADDR && addr_match && con3_q[C3_ADDRESS_HOLD_ENABLE])
                              || (st_q == ST_DATA && con3_q[C3_DATA_HOLD_ENABLE]));
    wire ack_clr = fall9 && ack_q && (con2_q[C2_SEN] || (st_q == ST_ADDR && rd_hit_q));
    wire tx_clr = fall9 && st_q == ST_TX;
    wire ckp_clr = hold_clr || ack_clr || tx_clr;
    // UA after ack slot of an acked 10-bit high write byte or of any 10-bit low byte
    wire ua_set = fall9 && st_q == ST_ADDR && tenbit && !rd_hit_q && (ack_q || low_ph_q);
    // irq after ack slot, or at hold point
    wire irq_set = (fall9 && (ack_q || ua_set)) || hold_clr || tx_clr
                   || (bus_start && con3_q[C3_SCIE] && enabled);
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            bf_q <= 1'b0;
            ua_q <= 1'b0;
            rw_q <= 1'b0;
            s_q <= 1'b0;
            p_q <= 1'b0;
            da_q <= 1'b0;
            irq_q <= 1'b0;
            ov_q <= 1'b0;
            buf_q <= 8'h00;
        end else begin
            // buffer read clears, new byte wins
            if (rx_byte) begin
                bf_q <= 1'b1;
                buf_q <= byte_w;
                da_q <= st_q == ST_DATA;
            end else if (rd_buf) begin
                bf_q <= 1'b0;
            end else if (wr_buf) begin
                buf_q <= REG_WDATA_I;
            end
            // overflow: a byte landing on a full buffer beats a software clear
            if (ov_set) begin
                ov_q <= 1'b1;
            end else if (wr_con1 && !REG_WDATA_I[C1_OV]) begin
                ov_q <= 1'b0;
            end
            if (fall8 && st_q == ST_ADDR && addr_match) begin
                rw_q <= byte_w[0];
            end
            // address write clears UA, set wins
            if (ua_set) begin
                ua_q <= 1'b1;
            end else if (wr_addr) begin
                ua_q <= 1'b0;
            end
            if (bus_start) begin
                s_q <= 1'b1;
                p_q <= 1'b0;
            end else if (bus_stop) begin
                s_q <= 1'b0;
                p_q <= 1'b1;
            end
            if (irq_set) begin
                irq_q <= 1'b1;
            end else if (wr_irq && !REG_WDATA_I[0]) begin
                irq_q <= 1'b0;
            end
        end
    end
    // clock release bit; hardware clear wins over a software write
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            ckp_q <= RST_CON1[C1_CKP];
        end else if (ckp_clr && enabled) begin
            ckp_q <= 1'b0;
        end else if (wr_con1) begin
            ckp_q <= REG_WDATA_I[C1_CKP];
        end
    end
    // ------------------------------------------------------------
    // software registers and read port
    // ------------------------------------------------------------
    wire [7:0] rd_mux = (REG_ADDR_I == OFS_STATUS) ? status_w :
                        (REG_ADDR_I == OFS_BUF) ? buf_q :
                        (REG_ADDR_I == OFS_ADDR) ? addr_q :
                        (REG_ADDR_I == OFS_MASK) ? mask_q :
                        (REG_ADDR_I == OFS_CON1) ? {con1_q[7], ov_q, con1_q[5], ckp_q, con1_q[3:0]} :
                        (REG_ADDR_I == OFS_CON2) ? con2_q :
                        (REG_ADDR_I == OFS_CON3) ? con3_q :
                        (REG_ADDR_I == OFS_CLKPS) ? clkps_q :
                        (REG_ADDR_I == OFS_DATPS) ? datps_q :
                        (REG_ADDR_I == OFS_IRQ) ? {7'h00, irq_q} : 8'h00;
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            addr_q <= RST_ZERO;
            mask_q <= RST_MASK;
            con1_q <= RST_CON1;
            con2_q <= RST_ZERO;
            con3_q <= RST_ZERO;
            clkps_q <= RST_ZERO;
            datps_q <= RST_ZERO;
            rdata_q <= 8'h00;
        end else begin
            if (REG_WR_I) begin
                // unmapped writes are dropped
                unique case (REG_ADDR_I)
                    OFS_ADDR: addr_q <= REG_WDATA_I;
                    OFS_MASK: mask_q <= REG_WDATA_I;
                    OFS_CON1: con1_q <= REG_WDATA_I;
                    OFS_CON2: con2_q <= REG_WDATA_I;
                    OFS_CON3: con3_q <= REG_WDATA_I;
                    OFS_CLKPS: clkps_q <= REG_WDATA_I;
                    OFS_DATPS: datps_q <= REG_WDATA_I;
                    default: ;
                endcase
            end
            rdata_q <= REG_RD_I ? rd_mux : 8'h00;
        end
    end
    // ------------------------------------------------------------
    // transmit shifter and pin drivers
    // ------------------------------------------------------------
    logic hold_q, sda_oe_q;
    // UA stretch in 10-bit mode, no CLOCK_RELEASE_BIT clear
    wire stretch_req = enabled && (!ckp_q || (ua_q && tenbit));
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            tx_q <= 8'h00;
            hold_q <= 1'b0;
            sda_oe_q <= 1'b0;
            SCL_O <= 1'b0;
            SDA_O <= 1'b0;
        end else begin
            if (wr_buf) begin
                tx_q <= REG_WDATA_I;
            end else if (st_q == ST_TX && scl_fall && cnt_q < BIT_LAST) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
            // join a low SCL, keep it until released
            hold_q <= stretch_req && (hold_q || !scl_s);
            SCL_O <= 1'b0;
            SDA_O <= 1'b0;
            if (st_q == ST_TX) begin
                sda_oe_q <= (cnt_q < BIT_LAST) && !tx_q[7];
            end else begin
                sda_oe_q <= (cnt_q == BIT_LAST) && ack_q && ack_drive;
            end
        end
    end
    assign SCL_OE_O = hold_q;
    assign SDA_OE_O = sda_oe_q;
    assign REG_RDATA_O = rdata_q;
    assign IRQ_FLAG_O = irq_q;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_START_FLAG: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        bus_start && enabled |=> s_q && (irq_q || !con3_q[C3_SCIE])) else $error("start not flagged");
    AST_BUF_CLEAR: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        rd_buf && !rx_byte |=> !bf_q) else $error("buffer read kept full flag");
    AST_LOW_MISS: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        fall9 && st_q == ST_ADDR && low_ph_q && !ack_q && !bf_q |=> ua_q && irq_q && !bf_q)
        else $error("low mismatch flags wrong");
    AST_UA_HOLD: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        enabled && tenbit && ua_q && !scl_s |=> SCL_OE_O) else $error("update address not stretching");
    AST_ADDR_RELEASE: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        wr_addr && !ua_set && ckp_q && !ckp_clr |=> ##1 !SCL_OE_O) else $error("address write kept SCL");
    AST_SEN_STRETCH: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        fall9 && ack_q && con2_q[C2_SEN] && enabled |=> !ckp_q) else $error("stretch enable ignored");
    AST_JOIN_LOW: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        $rose(SCL_OE_O) |-> !$past(scl_s)) else $error("pulled SCL while high");
    AST_HOLD_EDGE: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
        fall8 && st_q == ST_DATA && con3_q[C3_DATA_HOLD_ENABLE] && enabled |=> !ckp_q ##1 SCL_OE_O)
        else $error("data hold missed");
endmodule // i2cs_top

// ### test/i2cs_master_model.sv
// behavioural i2c bus master for the far side of the slave pins
// assumes the bench resolves both lines as wired-and with pull-ups
`timescale 1ns/1ns
module i2cs_master_model (
    // resolved bus levels
    input wire logic scl_i,
    input wire logic sda_i,
    // pull-down enables, high pulls the line low
    output logic scl_oe_o,
    output logic sda_oe_o
);
    // ------------------------------------------------------------
    // bus phases, one bit is 80 ns
    // ------------------------------------------------------------
    localparam int QTR = 20; // quarter bit
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // pause while stretched
    // let scl go, then follow the wired line so a held clock stalls us
    task automatic scl_high();
        scl_oe_o = 1'b0;
        wait (scl_i === 1'b1);
        #QTR;
    endtask
    // start or repeated start: sda falls while scl is high
    task automatic start_cond();
        sda_oe_o = 1'b0;
        #QTR;
        scl_high();
        sda_oe_o = 1'b1;
        #QTR;
        scl_oe_o = 1'b1;
        #QTR;
    endtask
    // eight bits msb first, then the ninth pulse samples the ack
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #QTR;
            sda_oe_o = ~b[i];
            #QTR;
            scl_high();
            #QTR;
            scl_oe_o = 1'b1;
        end
        #QTR;
        sda_oe_o = 1'b0;
        #QTR;
        scl_high();
        ack = (sda_i === 1'b0);
        #QTR;
        scl_oe_o = 1'b1;
        #QTR;
    endtask
    // stop: sda rises while scl is high
    task automatic stop_cond();
        #QTR;
        sda_oe_o = 1'b1;
        #QTR;
        scl_high();
        sda_oe_o = 1'b0;
        #QTR;
    endtask
endmodule // i2cs_master_model

// ### test/tb.sv
// self-checking bench for the i2c slave: 10-bit receive, holds, stretching
// assumes pull-ups on both lines and the master model on the far side
`timescale 1ns/1ns
module tb;
    import i2cs_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk = 1'b0; // 100 MHz
    logic rst = 1'b1; // held 12 cycles
    logic [REG_AW-1:0] r_addr = '0;
    logic [7:0] r_wd = 8'h00;
    logic r_wr = 1'b0;
    logic r_rd = 1'b0;
    logic [7:0] rdata;
    logic scl_o, scl_oe, sda_o, sda_oe, irq;
    logic m_scl_oe, m_sda_oe; // master pull-downs
    wire scl_line = ~(m_scl_oe | scl_oe); // wired-and with pull-up
    wire sda_line = ~(m_sda_oe | sda_oe);
    int failures = 0;
    int n_tests = 0;
    localparam logic [7:0] CON1_RUN = {2'b00, 1'b1, 1'b1, MODE_10BIT}; // enabled, clock released
    always #5 clk = ~clk;
    i2cs_top u_i2cs_top (.CLOCK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(r_addr), .REG_WDATA_I(r_wd),
        .REG_WR_I(r_wr), .REG_RD_I(r_rd), .REG_RDATA_O(rdata), .SCL_I(scl_line), .SCL_O(scl_o),
        .SCL_OE_O(scl_oe), .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .IRQ_FLAG_O(irq));
    i2cs_master_model u_i2cs_master_model (.scl_i(scl_line), .sda_i(sda_line), .scl_oe_o(m_scl_oe),
        .sda_oe_o(m_sda_oe));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // header byte of a 10-bit address with the direction bit
    function automatic logic [7:0] hi_byte(input logic [9:0] a, input logic rw);
        return {TENBIT_HDR, a[9:8], rw};
    endfunction
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        r_addr <= a;
        r_wd <= d;
        r_wr <= 1'b1;
        @(posedge clk);
        r_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        r_addr <= a;
        r_rd <= 1'b1;
        @(posedge clk);
        r_rd <= 1'b0;
        #1;
        chk(name, rdata & m, e);
    endtask
    // byte during which the slave must stall us before the ack
    task automatic hold_byte(input logic [7:0] b, output logic ack);
        int n;
        n = 0;
        fork
            u_i2cs_master_model.send_byte(b, ack);
            begin
                wait_clk(4);
                while (scl_oe !== 1'b1 && n < 400) begin
                    @(posedge clk);
                    n++;
                end
                rd_chk("ckp_hold", OFS_CON1, 8'h10, 8'h00);
                wr(OFS_CON1, CON1_RUN);
            end
        join
    endtask
    // software side of an address byte that set the update flag
    task automatic addr_step(input logic [7:0] got, input logic [7:0] nxt);
        wait_clk(6);
        rd_chk("ua_bf", OFS_STATUS, 8'h03, 8'h03);
        chk("irq_addr", {7'h0, irq}, 8'h01);
        chk("ua_hold", {7'h0, scl_oe}, 8'h01);
        chk("od_only", {6'h0, scl_o, sda_o}, 8'h00);
        rd_chk("ckp_kept", OFS_CON1, 8'h10, 8'h10);
        rd_chk("buf_addr", OFS_BUF, 8'hff, got);
        rd_chk("bf_clr", OFS_STATUS, 8'h01, 8'h00);
        wr(OFS_IRQ, 8'h00);
        wr(OFS_ADDR, nxt);
        wait_clk(3);
        chk("ua_rel", {7'h0, scl_oe}, 8'h00);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // the slave may pull scl only while the master already holds it low
    always @(posedge scl_oe) chk("scl_low_first", {7'h0, m_scl_oe}, 8'h01);
    // watchdog, far beyond the few thousand cycles the frames need
    initial begin
        #400000;
        failures++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic ack;
        logic [31:0] seed;
        logic [9:0] a10;
        logic [7:0] hi, lo, d;
        seed = lfsr(32'h568f1d1a);
        a10 = seed[9:0];
        hi = hi_byte(a10, 1'b0);
        lo = a10[7:0];
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // reset values, refused index, read-only status
        rd_chk("con1_rst", OFS_CON1, 8'hff, RST_CON1);
        rd_chk("mask_rst", OFS_MASK, 8'hff, RST_MASK);
        rd_chk("addr_rst", OFS_ADDR, 8'hff, RST_ZERO);
        wr(4'hf, 8'h5a);
        rd_chk("unmapped", 4'hf, 8'hff, 8'h00);
        wr(OFS_STATUS, 8'hff);
        rd_chk("stat_ro", OFS_STATUS, 8'hff, RST_ZERO);
        wr(OFS_ADDR, hi);
        wr(OFS_CON1, CON1_RUN);
        // start without its interrupt enabled, then a foreign header
        u_i2cs_master_model.start_cond();
        wait_clk(8);
        rd_chk("start_seen", OFS_STATUS, 8'h08, 8'h08);
        chk("irq_masked", {7'h0, irq}, 8'h00);
        u_i2cs_master_model.send_byte(hi_byte(a10 ^ 10'h300, 1'b0), ack);
        chk("nack_foreign", {7'h0, ack}, 8'h00);
        u_i2cs_master_model.stop_cond();
        // 10-bit write with start interrupt and stretching
        wr(OFS_CON3, 8'h20);
        u_i2cs_master_model.start_cond();
        wait_clk(8);
        chk("irq_start", {7'h0, irq}, 8'h01);
        wr(OFS_IRQ, 8'h00);
        u_i2cs_master_model.send_byte(hi, ack);
        chk("ack_hi", {7'h0, ack}, 8'h01);
        addr_step(hi, lo);
        u_i2cs_master_model.send_byte(lo, ack);
        chk("ack_lo", {7'h0, ack}, 8'h01);
        addr_step(lo, hi);
        wr(OFS_CON2, 8'h01);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            d = seed[7:0];
            u_i2cs_master_model.send_byte(d, ack);
            chk("ack_data", {7'h0, ack}, 8'h01);
            wait_clk(6);
            chk("irq_data", {7'h0, irq}, 8'h01);
            rd_chk("ckp_sen", OFS_CON1, 8'h50, (i == 2) ? 8'h40 : 8'h00);
            wait_clk(20);
            chk("sen_hold", {7'h0, scl_oe}, 8'h01);
            wr(OFS_IRQ, 8'h00);
            if (i != 1) rd_chk("buf_data", OFS_BUF, 8'hff, d);
            wr(OFS_CON1, CON1_RUN);
            wait_clk(3);
            chk("sen_rel", {7'h0, scl_oe}, 8'h00);
        end
        // repeated start with a read request
        wr(OFS_CON2, 8'h00);
        u_i2cs_master_model.start_cond();
        u_i2cs_master_model.send_byte(hi_byte(a10, 1'b1), ack);
        chk("ack_rd", {7'h0, ack}, 8'h01);
        wait_clk(6);
        rd_chk("ckp_rd", OFS_CON1, 8'h10, 8'h00);
        chk("rd_hold", {7'h0, scl_oe}, 8'h01);
        wr(OFS_BUF, 8'hff);
        wr(OFS_CON1, CON1_RUN);
        u_i2cs_master_model.stop_cond();
        // low address that does not match
        u_i2cs_master_model.start_cond();
        u_i2cs_master_model.send_byte(hi, ack);
        addr_step(hi, lo);
        u_i2cs_master_model.send_byte(~lo, ack);
        chk("nack_lo", {7'h0, ack}, 8'h00);
        wait_clk(6);
        rd_chk("ua_nobf", OFS_STATUS, 8'h03, 8'h02);
        chk("irq_miss", {7'h0, irq}, 8'h01);
        rd_chk("ckp_same", OFS_CON1, 8'h10, 8'h10);
        wr(OFS_IRQ, 8'h00);
        wr(OFS_ADDR, hi);
        u_i2cs_master_model.stop_cond();
        // address hold on both address bytes, then data hold
        wr(OFS_CON3, 8'h02);
        u_i2cs_master_model.start_cond();
        hold_byte(hi, ack);
        chk("ack_ahi", {7'h0, ack}, 8'h01);
        addr_step(hi, lo);
        hold_byte(lo, ack);
        chk("ack_alo", {7'h0, ack}, 8'h01);
        addr_step(lo, hi);
        wr(OFS_CON3, 8'h01);
        seed = lfsr(seed);
        hold_byte(seed[7:0], ack);
        chk("ack_dh", {7'h0, ack}, 8'h01);
        rd_chk("buf_dh", OFS_BUF, 8'hff, seed[7:0]);
        u_i2cs_master_model.stop_cond();
        wait_clk(10);
        wrap_up();
    end
endmodule // tb
